// file: tcc_pins_model.sv
// pin-side model: capture inputs, external clock and reset pins
`timescale 1ns/10ps
module tcc_pins_model
  import tcc_pkg::*;
(
  input  wire logic             clk_i,
  output logic      [N_CAP-1:0] cap_o,
  output logic                  ext_clk_o,
  output logic                  rst_pin_o
);
  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  // idle levels before any test
  initial begin
    cap_o     = 4'h0;
    ext_clk_o = 1'b0;
    rst_pin_o = 1'b0;
  end

  // rising edges 13 or more cycles apart
  task automatic clk_pulses(input int n, input int half);
    repeat (n) begin
      @(posedge clk_i) ext_clk_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (half) @(posedge clk_i);
    end
  endtask

  // one capture pin level, held a few cycles
  task automatic set_cap(input int n, input logic v);
    logic [N_CAP-1:0] m;
    m = N_CAP'(1) << n;
    @(posedge clk_i) cap_o <= v ? (cap_o | m) : (cap_o & ~m);
    repeat (3) @(posedge clk_i);
  endtask

  // one rising edge on the timer reset pin
  task automatic rst_pulse();
    @(posedge clk_i) rst_pin_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_pin_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// file: tcc_pkg.sv
// package: register map, field layouts and constants of the capture timer
package tcc_pkg;

  // ---------------------------------------------------------------
  // bus and structure sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int CNT_W       = 16;
  localparam int N_CAP       = 4;
  localparam int N_CMP       = 3;
  localparam int SYS_DIV_DEF = 12;   // machine rate is clock / 12

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS    = 8'hC8;
  localparam logic [7:0] OFS_CTRL     = 8'hEA;
  localparam logic [7:0] OFS_EDGE     = 8'hEB;
  localparam logic [7:0] OFS_SETEN    = 8'hEE;
  localparam logic [7:0] OFS_CLRTOG   = 8'hEF;
  localparam logic [7:0] OFS_PORT     = 8'hC0;
  localparam logic [7:0] OFS_CNT_LO   = 8'hD0;
  localparam logic [7:0] OFS_CNT_HI   = 8'hD1;
  localparam logic [7:0] OFS_CAP_BASE = 8'hD2; // lo at base+2n, hi +1
  localparam logic [7:0] OFS_CMP_BASE = 8'hDA; // lo at base+2n, hi +1

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [15:0] WORD_ONE    = 16'h0001;
  localparam logic [15:0] WORD_MAX    = 16'hFFFF;
  localparam logic [7:0]  BYTE_MAX    = 8'hFF;
  localparam logic [7:0]  SETCLR_MASK = 8'h3F;  // port bits 5..0
  localparam logic [7:0]  TOG_MASK    = 8'hC0;  // port bits 7..6
  localparam logic [2:0]  PSC_RST     = 3'h0;
  localparam logic [2:0]  PSC_ONE     = 3'h1;
  localparam int          TOG_LO_BIT  = 6;
  localparam int          TOG_HI_BIT  = 7;

  // ---------------------------------------------------------------
  // clock source and prescaler codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_OFF  = 2'h0;
  localparam logic [1:0] SRC_SYS  = 2'h1;
  localparam logic [1:0] SRC_TEST = 2'h2;
  localparam logic [1:0] SRC_PIN  = 2'h3;
  localparam logic [1:0] PSC_D1   = 2'h0;
  localparam logic [1:0] PSC_D2   = 2'h1;
  localparam logic [1:0] PSC_D4   = 2'h2;
  localparam logic [1:0] PSC_D8   = 2'h3;

  // control register, bit 7 first
  typedef struct packed {
    logic       word_overflow_irq_select;
    logic       byte_overflow_irq_select;
    logic       ext_reset_enable;
    logic       byte_overflow_flag;
    logic [1:0] prescale_sel;
    logic [1:0] source_sel;
  } tcc_ctrl_t;

  // event flag register, bit 7 first
  typedef struct packed {
    logic       word_overflow_flag;
    logic [2:0] cmp_flags;   // c, b, a
    logic [3:0] cap_flags;   // d, c, b, a
  } tcc_flags_t;

endpackage

// file: tcc_top.sv
// capture/compare timer: counter, prescaler, captures, compares, port
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module tcc_top
  import tcc_pkg::*;
#(
  parameter int SYS_DIV = SYS_DIV_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  input  wire logic [N_CAP-1:0]  capture_in_i,
  input  wire logic              ext_clk_i,
  input  wire logic              ext_timer_reset_pin_i,
  input  wire logic              low_power_i,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic      [DATA_W-1:0] port_o,
  output logic                   ovf_irq_o
);

  // ---------------------------------------------------------------
  // elaboration checks and helpers
  // ---------------------------------------------------------------
  if (SYS_DIV < 2 || SYS_DIV > 256) begin : g_bad_div
    $error("SYS_DIV must lie between 2 and 256");
  end

  localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);

  // terminal prescaler count for a divide code
  function automatic logic [2:0] div_last(input logic [1:0] sel);
    logic [2:0] r;
    r = PSC_RST;
    unique case (sel)
      PSC_D1: r = 3'h0;
      PSC_D2: r = 3'h1;
      PSC_D4: r = 3'h3;
      PSC_D8: r = 3'h7;
    endcase
    return r;
  endfunction

  // address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tcc_ctrl_t   ctl_r;
  tcc_flags_t  flags_r;
  logic [7:0]  edge_r;
  logic [7:0]  seten_r;
  logic [7:0]  clrtog_r;
  logic [7:0]  port_r;
  logic [7:0]  port_nxt;
  logic [7:0]  seten_nxt;
  logic [7:0]  rd_nxt;
  logic [15:0] cnt_r;
  logic [2:0]  psc_r;
  logic [7:0]  sysdiv_r;
  logic        ext_clk_q;
  logic        ext_rst_q;
  logic [N_CAP-1:0] cap_q;
  logic [N_CAP-1:0] cap_evt;
  logic [N_CMP-1:0] eq_now;
  logic [N_CMP-1:0] eq_q;
  logic [N_CMP-1:0] cmp_evt;
  logic [15:0] cap_r [N_CAP];
  logic [15:0] cmp_r [N_CMP];
  logic        irq_r;
  logic        sys_tick;
  logic        src_edge;
  logic        psc_clr;
  logic        cnt_tick;
  logic        ext_rst_evt;
  logic        cfg_change;
  logic        byte_ovf;
  logic        word_ovf;
  logic        wr_ctl;
  logic        wr_flags;
  logic        wr_port;
  logic        wr_seten;

  assign wr_ctl   = wr_en_i && hit(addr_i, OFS_CTRL);
  assign wr_flags = wr_en_i && hit(addr_i, OFS_FLAGS);
  assign wr_port  = wr_en_i && hit(addr_i, OFS_PORT);
  assign wr_seten = wr_en_i && hit(addr_i, OFS_SETEN);

  // ---------------------------------------------------------------
  // clock source and prescaler
  // ---------------------------------------------------------------
  // machine-rate enable divider
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sysdiv_r <= REG_RST;
    end else if (sysdiv_r == SYS_LAST) begin
      sysdiv_r <= REG_RST;
    end else begin
      sysdiv_r <= sysdiv_r + 8'h01;
    end
  end

  assign sys_tick = (sysdiv_r == SYS_LAST);

  // pin history for edge detection
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_clk_q <= 1'b0;
      ext_rst_q <= 1'b0;
      cap_q     <= '0;
    end else begin
      ext_clk_q <= ext_clk_i;
      ext_rst_q <= ext_timer_reset_pin_i;
      cap_q     <= capture_in_i;
    end
  end

  always_comb begin
    unique case (ctl_r.source_sel)
      SRC_SYS: src_edge = sys_tick;
      SRC_PIN: src_edge = ext_clk_i && !ext_clk_q; // pin held slow enough
      default: src_edge = 1'b0;                    // off and test mode
    endcase
  end

  assign ext_rst_evt = ctl_r.ext_reset_enable &&
                       ext_timer_reset_pin_i && !ext_rst_q;
  assign cfg_change  = wr_ctl && (wr_data_i[3:0] != ctl_r[3:0]);
  assign psc_clr     = low_power_i || ext_rst_evt || cfg_change;
  // counter step when prescaler reaches its terminal count
  assign cnt_tick    = src_edge && !psc_clr &&
                       (psc_r == div_last(ctl_r.prescale_sel));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      psc_r <= PSC_RST;
    end else if (psc_clr || cnt_tick) begin
      psc_r <= PSC_RST;
    end else if (src_edge) begin
      psc_r <= psc_r + PSC_ONE;
    end
  end

  // ---------------------------------------------------------------
  // counter and overflow
  // ---------------------------------------------------------------
  // low power holds cleared; pin reset
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= WORD_RST;
    end else if (low_power_i || ext_rst_evt) begin
      cnt_r <= WORD_RST;
    end else if (cnt_tick) begin
      cnt_r <= cnt_r + WORD_ONE;
    end
  end

  assign byte_ovf = cnt_tick && (cnt_r[7:0] == BYTE_MAX);
  assign word_ovf = cnt_tick && (cnt_r == WORD_MAX);

  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  // per-input edge qualification
  for (genvar i = 0; i < N_CAP; i++) begin : g_cap
    assign cap_evt[i] = (capture_in_i[i] && !cap_q[i] && edge_r[2*i]) ||
                        (!capture_in_i[i] && cap_q[i] && edge_r[2*i+1]);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < N_CAP; i++) begin
        cap_r[i] <= WORD_RST;
      end
    end else begin
      for (int i = 0; i < N_CAP; i++) begin
        if (cap_evt[i]) begin
          cap_r[i] <= cnt_r;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // compare
  // ---------------------------------------------------------------
  // continuous equality; act only on first equal cycle
  for (genvar j = 0; j < N_CMP; j++) begin : g_cmp
    assign eq_now[j]  = (cnt_r == cmp_r[j]);
    assign cmp_evt[j] = eq_now[j] && !eq_q[j];
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eq_q <= '1;
    end else begin
      eq_q <= eq_now;
    end
  end

  // compare registers cleared by reset, byte-wise writes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int j = 0; j < N_CMP; j++) begin
        cmp_r[j] <= WORD_RST;
      end
    end else if (wr_en_i) begin
      for (int j = 0; j < N_CMP; j++) begin
        if (hit(addr_i, OFS_CMP_BASE + 8'(2*j))) begin
          cmp_r[j][7:0] <= wr_data_i;
        end
        if (hit(addr_i, OFS_CMP_BASE + 8'(2*j+1))) begin
          cmp_r[j][15:8] <= wr_data_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output port
  // ---------------------------------------------------------------
  always_comb begin
    // software write first, match actions applied on top
    port_nxt = wr_port ? wr_data_i : port_r;
    if (cmp_evt[0]) begin
      port_nxt = port_nxt | (seten_r & SETCLR_MASK);
    end
    // clear on second compare; applied after set so clear wins
    if (cmp_evt[1]) begin
      port_nxt = port_nxt & ~(clrtog_r & SETCLR_MASK);
    end
    // toggle bits 7:6; direction picks level; enables
    if (cmp_evt[2]) begin
      for (int b = TOG_LO_BIT; b <= TOG_HI_BIT; b++) begin
        if (clrtog_r[b]) begin
          port_nxt[b] = !seten_r[b];
        end
      end
    end
  end

  // direction flips after each performed toggle
  always_comb begin
    seten_nxt = wr_seten ? wr_data_i : seten_r;
    if (cmp_evt[2]) begin
      seten_nxt = seten_nxt ^ (clrtog_r & TOG_MASK);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_r  <= REG_RST;
      seten_r <= REG_RST;
    end else begin
      port_r  <= port_nxt;
      seten_r <= seten_nxt;
    end
  end

  // ---------------------------------------------------------------
  // software registers and flags
  // ---------------------------------------------------------------
  // plain configuration registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_r   <= REG_RST;
      clrtog_r <= REG_RST;
    end else if (wr_en_i) begin
      if (hit(addr_i, OFS_EDGE)) begin
        edge_r <= wr_data_i;
      end
      if (hit(addr_i, OFS_CLRTOG)) begin
        clrtog_r <= wr_data_i;
      end
    end
  end

  // control fields; byte overflow flag, set wins over write
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_r <= REG_RST;
    end else begin
      if (wr_ctl) begin
        ctl_r <= wr_data_i;
      end
      if (byte_ovf) begin
        ctl_r.byte_overflow_flag <= 1'b1;
      end
    end
  end

  // flag layout; only software clears, hardware set wins
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= REG_RST;
    end else begin
      flags_r <= (wr_flags ? tcc_flags_t'(wr_data_i) : flags_r) |
                 tcc_flags_t'({word_ovf, cmp_evt, cap_evt});
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (ctl_r.byte_overflow_irq_select &&
                ctl_r.byte_overflow_flag) ||
               (ctl_r.word_overflow_irq_select &&
                flags_r.word_overflow_flag);
    end
  end

  always_comb begin
    rd_nxt = REG_RST;
    if (hit(addr_i, OFS_FLAGS))  rd_nxt = flags_r;
    if (hit(addr_i, OFS_CTRL))   rd_nxt = ctl_r;
    if (hit(addr_i, OFS_EDGE))   rd_nxt = edge_r;
    if (hit(addr_i, OFS_SETEN))  rd_nxt = seten_r;
    if (hit(addr_i, OFS_CLRTOG)) rd_nxt = clrtog_r;
    if (hit(addr_i, OFS_PORT))   rd_nxt = port_r;
    if (hit(addr_i, OFS_CNT_LO)) rd_nxt = cnt_r[7:0];
    if (hit(addr_i, OFS_CNT_HI)) rd_nxt = cnt_r[15:8];
    for (int i = 0; i < N_CAP; i++) begin
      if (hit(addr_i, OFS_CAP_BASE + 8'(2*i)))   rd_nxt = cap_r[i][7:0];
      if (hit(addr_i, OFS_CAP_BASE + 8'(2*i+1))) rd_nxt = cap_r[i][15:8];
    end
    for (int j = 0; j < N_CMP; j++) begin
      if (hit(addr_i, OFS_CMP_BASE + 8'(2*j)))   rd_nxt = cmp_r[j][7:0];
      if (hit(addr_i, OFS_CMP_BASE + 8'(2*j+1))) rd_nxt = cmp_r[j][15:8];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= REG_RST;
    end else begin
      rd_data_o <= rd_en_i ? rd_nxt : REG_RST;
    end
  end

  assign port_o    = port_r;
  assign ovf_irq_o = irq_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_psc_div;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (cnt_r == $past(cnt_r) + WORD_ONE) |->
        ($past(psc_r) == div_last($past(ctl_r.prescale_sel)));
  endproperty
  a_psc_div: assert property (p_psc_div)
    else $error("counter stepped before prescaler terminal count");

  property p_src_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ctl_r.source_sel == SRC_OFF && !psc_clr) |=> $stable(cnt_r);
  endproperty
  a_src_off: assert property (p_src_off)
    else $error("counter moved with source off");

  property p_cfg_clr;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      cfg_change |=> (psc_r == PSC_RST);
  endproperty
  a_cfg_clr: assert property (p_cfg_clr)
    else $error("prescaler not cleared on config change");

  property p_pin_rst;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ctl_r.ext_reset_enable && ext_timer_reset_pin_i && !ext_rst_q)
        |=> (cnt_r == WORD_RST);
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("counter not cleared by reset pin edge");

  property p_low_pwr;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      low_power_i |=> (cnt_r == WORD_RST && psc_r == PSC_RST);
  endproperty
  a_low_pwr: assert property (p_low_pwr)
    else $error("counter or prescaler running in low power");

  property p_cap_a;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      cap_evt[0] |=> (cap_r[0] == $past(cnt_r) && flags_r.cap_flags[0]);
  endproperty
  a_cap_a: assert property (p_cap_a)
    else $error("capture a did not load counter and flag");

  sequence s_first_eq;
    !eq_q[0] && (cnt_r == cmp_r[0]);
  endsequence
  sequence s_set_seen;
    flags_r.cmp_flags[0] && ((port_r & $past(seten_r) & SETCLR_MASK) ==
                             ($past(seten_r) & SETCLR_MASK));
  endsequence
  property p_cmp_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_first_eq ##0 !cmp_evt[1]) |=> s_set_seen;
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("first compare match did not set port and flag");

  property p_clr_wins;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (cmp_evt[0] && cmp_evt[1]) |=>
        ((port_r & $past(clrtog_r) & SETCLR_MASK) == REG_RST);
  endproperty
  a_clr_wins: assert property (p_clr_wins)
    else $error("clear did not win over set");

  property p_no_hw_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !wr_flags |=> ((~flags_r & $past(flags_r)) == REG_RST);
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear)
    else $error("flag cleared without software write");

  property p_cnt_read;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (rd_en_i && addr_i == OFS_CNT_LO) |=>
        (rd_data_o == $past(cnt_r[7:0]));
  endproperty
  a_cnt_read: assert property (p_cnt_read)
    else $error("counter low byte read not live");

  property p_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      ((ctl_r.byte_overflow_irq_select && ctl_r.byte_overflow_flag) ||
       (ctl_r.word_overflow_irq_select && flags_r.word_overflow_flag))
        |=> ovf_irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("overflow interrupt missing");

endmodule

// file: tcc_top_tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/10ps
module tcc_top_tb;
  import tcc_pkg::*;
  logic              core_clk_i  = 1'b0;
  logic              reset_n_i   = 1'b0;
  logic [ADDR_W-1:0] addr_i      = 8'h00;
  logic [DATA_W-1:0] wr_data_i   = 8'h00;
  logic              wr_en_i     = 1'b0;
  logic              rd_en_i     = 1'b0;
  logic              low_power_i = 1'b0;
  logic              rd_v        = 1'b0;
  logic [N_CAP-1:0]  cap_w;
  logic              ext_clk_w;
  logic              rst_pin_w;
  logic [DATA_W-1:0] rd_data_o;
  logic [DATA_W-1:0] port_o;
  logic              ovf_irq_o;
  logic [8:0]        exp_q[$];
  logic [8:0]        item;
  logic [7:0]        last_rd, val, set_m, clr_m;
  logic [15:0]       exp_cnt;
  int                errors = 0;
  int                n_compared = 0;
  int                cycles = 0;

  tcc_top #(.SYS_DIV(2)) tcc_top_inst (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .capture_in_i(cap_w), .ext_clk_i(ext_clk_w),
    .ext_timer_reset_pin_i(rst_pin_w), .low_power_i(low_power_i),
    .rd_data_o(rd_data_o), .port_o(port_o), .ovf_irq_o(ovf_irq_o));
  tcc_pins_model tcc_pins_model_inst (
    .clk_i(core_clk_i), .cap_o(cap_w), .ext_clk_o(ext_clk_w),
    .rst_pin_o(rst_pin_w));

  // ---------------------------------------------------------------
  // clock, timeout, checking
  // ---------------------------------------------------------------
  initial forever #20 core_clk_i = ~core_clk_i;

  // cut a hang short
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // read data stand one cycle after the strobe edge
  always @(posedge core_clk_i) rd_v <= rd_en_i;
  always @(negedge core_clk_i) begin
    if (rd_v && exp_q.size() > 0) begin
      item = exp_q.pop_front();
      last_rd = rd_data_o;
      if (!item[8]) check(rd_data_o, item[7:0]);
    end
  end

  // ---------------------------------------------------------------
  // bus and pin helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_en_i   <= w;
    rd_en_i   <= ~w;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic rd_any(input logic [7:0] a);
    exp_q.push_back(9'h100);
    bus(1'b0, a, 8'h00);
    @(posedge core_clk_i);
  endtask
  task automatic chk_cnt();
    rd(OFS_CNT_LO, exp_cnt[7:0]);
    rd(OFS_CNT_HI, exp_cnt[15:8]);
  endtask
  task automatic tick(input int n, input int p);
    tcc_pins_model_inst.clk_pulses(n, 6);
    exp_cnt = exp_cnt + 16'(n >> p);
  endtask
  task automatic cap(input int n, input logic v);
    tcc_pins_model_inst.set_cap(n, v);
  endtask
  task automatic wcmp(input int i, input logic [15:0] v);
    wr(OFS_CMP_BASE + 8'(2 * i), v[7:0]);
    wr(OFS_CMP_BASE + 8'(2 * i + 1), v[15:8]);
  endtask
  task automatic port_is(input logic [7:0] e);
    rd(OFS_PORT, e);
    @(negedge core_clk_i);
    check(port_o, e);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check({7'h00, ovf_irq_o}, {7'h00, e});
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    val = 8'($urandom(96));
    exp_cnt = 16'h0000;
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) rd(OFS_CMP_BASE + 8'(i), 8'h00);
    rd(OFS_CTRL, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h10, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      val = 8'($urandom);
      wr(i == 0 ? OFS_FLAGS : OFS_EDGE + 8'(i == 1 ? 0 : i + 1), val);
      rd(i == 0 ? OFS_FLAGS : OFS_EDGE + 8'(i == 1 ? 0 : i + 1), val);
      wr(i == 0 ? OFS_FLAGS : OFS_EDGE + 8'(i == 1 ? 0 : i + 1), 8'h00);
    end
    $display("test registers done");
    wr(OFS_CTRL, {4'h0, PSC_D1, SRC_PIN});
    tick(5, 0);
    chk_cnt();
    wr(OFS_CNT_LO, 8'hFF);
    chk_cnt();
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CTRL, {4'h0, 2'(p), SRC_PIN});
      tick(8, p);
      chk_cnt();
    end
    // a source or division change drops partial counts
    wr(OFS_CTRL, {4'h0, PSC_D2, SRC_PIN});
    tcc_pins_model_inst.clk_pulses(1, 9);
    wr(OFS_CTRL, {4'h0, PSC_D4, SRC_PIN});
    tcc_pins_model_inst.clk_pulses(3, 6);
    chk_cnt();
    tick(1, 0);
    chk_cnt();
    for (int s = 0; s < 3; s += 2) begin
      wr(OFS_CTRL, {4'h0, PSC_D1, 2'(s)});
      tcc_pins_model_inst.clk_pulses(2, 6);
      chk_cnt();
    end
    tcc_pins_model_inst.rst_pulse();
    chk_cnt();
    wr(OFS_CTRL, 8'h23);
    tcc_pins_model_inst.rst_pulse();
    exp_cnt = 16'h0000;
    chk_cnt();
    wr(OFS_CTRL, {4'h0, PSC_D1, SRC_SYS});
    repeat (40) @(posedge core_clk_i);
    wr(OFS_CTRL, 8'h20);
    rd_any(OFS_CNT_LO);
    check({7'h00, last_rd >= 8'h13 && last_rd <= 8'h17}, 8'h01);
    tcc_pins_model_inst.rst_pulse();
    wr(OFS_CTRL, {4'h0, PSC_D1, SRC_PIN});
    tick(3, 0);
    low_power_i <= 1'b1;
    tcc_pins_model_inst.clk_pulses(2, 6);
    exp_cnt = 16'h0000;
    chk_cnt();
    low_power_i <= 1'b0;
    tick(2, 0);
    chk_cnt();
    $display("test counter done");
    // byte overflow raises, masks and clears the interrupt
    wr(OFS_CTRL, 8'h41);
    repeat (600) @(posedge core_clk_i);
    wr(OFS_CTRL, 8'h50);
    rd(OFS_CTRL, 8'h50);
    irq_is(1'b1);
    wr(OFS_CTRL, 8'h10);
    irq_is(1'b0);
    rd(OFS_CTRL, 8'h10);
    wr(OFS_CTRL, 8'h50);
    irq_is(1'b1);
    wr(OFS_CTRL, 8'h60);
    irq_is(1'b0);
    tcc_pins_model_inst.rst_pulse();
    exp_cnt = 16'h0000;
    wr(OFS_CTRL, {4'h0, PSC_D1, SRC_PIN});
    wr(OFS_FLAGS, 8'h00);
    $display("test overflow done");
    for (int n = 0; n < 4; n++) begin
      tick(1 + n, 0);
      wr(OFS_EDGE, 8'h00);
      cap(n, 1'b1);
      cap(n, 1'b0);
      rd(OFS_FLAGS, 8'h00);
      wr(OFS_EDGE, 8'(1 << (2 * n)));
      cap(n, 1'b1);
      rd(OFS_FLAGS, 8'(1 << n));
      rd(OFS_CAP_BASE + 8'(2 * n), exp_cnt[7:0]);
      rd(OFS_CAP_BASE + 8'(2 * n + 1), exp_cnt[15:8]);
      wr(OFS_FLAGS, 8'h00);
      wr(OFS_EDGE, 8'(2 << (2 * n)));
      tick(1, 0);
      cap(n, 1'b0);
      rd(OFS_FLAGS, 8'(1 << n));
      rd(OFS_CAP_BASE + 8'(2 * n), exp_cnt[7:0]);
      wr(OFS_FLAGS, 8'h00);
    end
    $display("test capture done");
    set_m = 8'($urandom) & SETCLR_MASK;
    clr_m = 8'($urandom) & SETCLR_MASK;
    wr(OFS_SETEN, set_m);
    wr(OFS_CLRTOG, clr_m | TOG_MASK);
    wcmp(0, exp_cnt + 16'h0001);
    wcmp(1, exp_cnt + 16'h0003);
    wcmp(2, exp_cnt + 16'h0002);
    tick(1, 0);
    port_is(set_m);
    rd(OFS_FLAGS, 8'h10);
    tick(1, 0);
    port_is(set_m | TOG_MASK);
    rd(OFS_SETEN, set_m | TOG_MASK);
    tick(1, 0);
    port_is(set_m & ~clr_m | TOG_MASK);
    rd(OFS_FLAGS, 8'h70);
    wr(OFS_PORT, 8'hFF);
    port_is(8'hFF);
    wr(OFS_SETEN, 8'hFF);
    for (int i = 0; i < 3; i++) wcmp(i, exp_cnt + 16'h0001);
    tick(1, 0);
    port_is(SETCLR_MASK & ~clr_m);
    rd(OFS_SETEN, SETCLR_MASK);
    $display("test compare done");
    // let the pending read data be checked before reset clears them
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    exp_cnt = 16'h0000;
    chk_cnt();
    rd(OFS_CMP_BASE, 8'h00);
    port_is(8'h00);
    $display("test reset done");
    repeat (4) @(posedge core_clk_i);
    final_report();
  end
endmodule
